// File: hdl/tmes_pkg.sv
package tmes_pkg;
   // control register 0 field positions
   localparam int CTL0_ON_POS = 7;
   localparam int CTL0_OUT_POS = 5;
   localparam int CTL0_WIDE_POS = 4;
   // control register 1 field positions
   localparam int CTL1_CS_POS = 5;
   localparam int CTL1_ASYNC_POS = 4;
   // reset values
   localparam logic [7:0] CTL0_RESET = 8'h00;
   localparam logic [7:0] CTL1_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   // synchronous mode steps at most once per four system clocks
   localparam int SYNC_DIV = 4;
   localparam logic [1:0] SYNC_DIV_LAST = 2'(SYNC_DIV - 1);
   localparam int PRE_BITS = 15;
   localparam int CLK_SRC_NUM = 8;

   typedef struct packed {
      logic on;
      logic wide;
      logic [3:0] out_div;
      logic [2:0] clk_src;
      logic async_sel;
      logic [3:0] in_div;
   } tmes_cfg_t;

   typedef struct packed {
      logic wr_low;
      logic wr_high;
      logic rd_low;
      logic wr_ctl0;
      logic wr_ctl1;
      logic [7:0] wdata;
   } tmes_acc_t;

   typedef enum logic [1:0] {
      TMES_IDLE = 2'b00,
      TMES_RUN = 2'b01,
      TMES_SLEEP = 2'b11
   } tmes_state_t;
endpackage

// File: hdl/tmes_prescaler.sv
`timescale 1ns/10ps
module tmes_prescaler
   import tmes_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // control
   input wire logic i_clear,
   input wire logic i_edge,
   input wire logic [3:0] i_ratio,
   // result
   output logic o_tick
);
   logic [PRE_BITS-1:0] cnt_q;
   logic [PRE_BITS-1:0] cnt_d;
   logic [PRE_BITS:0] mask;

   // counter is internal only, no software view
   always_comb begin
      mask = (16'(1) << i_ratio) - 16'(1);
      cnt_d = cnt_q;
      o_tick = 1'b0;
      if (i_clear) begin
         cnt_d = '0;
      end else if (i_edge) begin
         if (({1'b0, cnt_q} & mask) == mask) begin
            cnt_d = '0;
            o_tick = 1'b1;
         end else begin
            cnt_d = cnt_q + PRE_BITS'(1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

// File: hdl/tmes_timer.sv
`timescale 1ns/10ps
// Summary of operation
// - width select bit picks 8-bit period counter or 16-bit counter
// - counter steps on rising edges of the prescaled selected source
// - 8-bit mode compares low count against a buffered period copy
// - on match low count clears and period is copied into buffer
// - reading low count in 16-bit mode latches high byte into high register
// - high writes buffer; low write in 16-bit mode loads both halves together
// - 16-bit count wraps past FFFF to zero and runs freely
// - no period reload happens in 16-bit mode
// - clock source field picks which clock input drives the timer
// - synchronous mode steps at most once per four system clocks
// - synchronous mode stops while the device sleeps
// - asynchronous mode steps on every prescaled source edge directly
// - asynchronous mode keeps counting during sleep
// - prescaler offers sixteen power-of-two ratios, 1:1 to 1:32768
// - prescaler counter is hidden from software
// - prescaler clears on low write, control writes and reset
// - output toggles per match or rollover, divided by postscaler
// - postscaler ratios 1:1 to 1:16, cleared like the prescaler
// - every output toggle sets the flag; enable raises an interrupt
// - timer counts only while its enable bit is one
module tmes_timer
   import tmes_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // configuration and software access
   input wire tmes_cfg_t i_cfg,
   input wire tmes_acc_t i_acc,
   input wire logic i_irq_enable,
   input wire logic i_flag_clear,
   input wire logic i_sleep,
   // candidate clock sources, sampled as synchronous levels
   input wire logic [CLK_SRC_NUM-1:0] i_clk_src,
   // status
   output logic [7:0] o_count_low,
   output logic [7:0] o_period_high,
   output logic o_timer_output_toggle,
   output logic o_timer_irq_flag,
   output logic o_irq
);
   logic src_q, src_d;
   logic [1:0] div_q, div_d;
   logic pend_q, pend_d;
   logic [7:0] low_q, low_d;
   logic [7:0] high_q, high_d;
   logic [7:0] hreg_q, hreg_d;
   logic [7:0] pbuf_q, pbuf_d;
   logic [3:0] post_q, post_d;
   logic out_q, out_d;
   logic flag_q, flag_d;
   tmes_state_t st_q, st_d;
   logic src_now, src_rise, pre_tick, step, event_hit, toggle, clr;

   assign clr = i_acc.wr_low | i_acc.wr_ctl0 | i_acc.wr_ctl1;
   assign src_now = i_clk_src[i_cfg.clk_src];
   assign src_rise = src_now & ~src_q;

   tmes_prescaler u_pre (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_clear(clr),
      .i_edge(src_rise & (st_q != TMES_IDLE)),
      .i_ratio(i_cfg.in_div),
      .o_tick(pre_tick)
   );

   // mode state: sync mode parks during sleep, async keeps running
   always_comb begin
      st_d = st_q;
      case (st_q)
         TMES_IDLE: begin
            if (i_cfg.on) st_d = TMES_RUN;
         end
         TMES_RUN: begin
            if (!i_cfg.on) st_d = TMES_IDLE;
            else if (i_sleep && !i_cfg.async_sel) st_d = TMES_SLEEP;
         end
         TMES_SLEEP: begin
            if (!i_cfg.on) st_d = TMES_IDLE;
            else if (!i_sleep || i_cfg.async_sel) st_d = TMES_RUN;
         end
         default: st_d = TMES_IDLE;
      endcase
   end

   // sync mode holds a tick until the divided system clock slot comes round
   always_comb begin
      src_d = src_now;
      div_d = div_q + 2'(1);
      pend_d = pend_q;
      step = 1'b0;
      if (clr) begin
         pend_d = 1'b0;
      end else if (st_q == TMES_RUN && i_cfg.async_sel) begin
         step = pre_tick;
      end else if (st_q == TMES_RUN) begin
         if (pre_tick) pend_d = 1'b1;
         if (div_q == SYNC_DIV_LAST && (pend_q || pre_tick)) begin
            step = 1'b1;
            pend_d = 1'b0;
         end
      end
   end

   // count, buffers and output
   always_comb begin
      low_d = low_q;
      high_d = high_q;
      hreg_d = hreg_q;
      pbuf_d = pbuf_q;
      post_d = post_q;
      out_d = out_q;
      flag_d = flag_q;
      event_hit = 1'b0;
      toggle = 1'b0;
      if (i_acc.wr_high) hreg_d = i_acc.wdata;
      if (i_acc.rd_low && i_cfg.wide) hreg_d = high_q;
      if (i_acc.wr_low) begin
         low_d = i_acc.wdata;
         if (i_cfg.wide) high_d = hreg_q;
      end else if (step) begin
         if (!i_cfg.wide) begin
            if (low_q == pbuf_q) begin
               low_d = 8'h00;
               pbuf_d = hreg_q;
               event_hit = 1'b1;
            end else begin
               low_d = low_q + 8'h01;
            end
         end else begin
            {high_d, low_d} = {high_q, low_q} + 16'h0001;
            event_hit = ({high_q, low_q} == 16'hFFFF);
         end
      end
      if (clr) begin
         post_d = 4'h0;
      end else if (event_hit) begin
         if (post_q == i_cfg.out_div) begin
            post_d = 4'h0;
            toggle = 1'b1;
         end else begin
            post_d = post_q + 4'h1;
         end
      end
      if (toggle) out_d = ~out_q;
      // a toggle in the clearing cycle wins over the clear
      if (toggle) flag_d = 1'b1;
      else if (i_flag_clear) flag_d = 1'b0;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         src_q <= 1'b0;
         div_q <= 2'h0;
         pend_q <= 1'b0;
         low_q <= COUNT_RESET;
         high_q <= COUNT_RESET;
         hreg_q <= COUNT_RESET;
         pbuf_q <= COUNT_RESET;
         post_q <= 4'h0;
         out_q <= 1'b0;
         flag_q <= 1'b0;
         st_q <= TMES_IDLE;
      end else begin
         src_q <= src_d;
         div_q <= div_d;
         pend_q <= pend_d;
         low_q <= low_d;
         high_q <= high_d;
         hreg_q <= hreg_d;
         pbuf_q <= pbuf_d;
         post_q <= post_d;
         out_q <= out_d;
         flag_q <= flag_d;
         st_q <= st_d;
      end
   end

   assign o_count_low = low_q;
   assign o_period_high = hreg_q;
   assign o_timer_output_toggle = out_q;
   assign o_timer_irq_flag = flag_q;
   assign o_irq = flag_q & i_irq_enable;

   // assertions
   hold_when_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (!i_cfg.on && st_q == TMES_IDLE && !i_acc.wr_low) |=> $stable(low_q) && $stable(out_q))
      else $error("count moved while disabled");
   match_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (step && !i_cfg.wide && !i_acc.wr_low && low_q == pbuf_q) |=> low_q == 8'h00)
      else $error("low count not cleared on match");
   wrap_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (step && i_cfg.wide && !i_acc.wr_low && {high_q, low_q} == 16'hFFFF)
      |=> {high_q, low_q} == 16'h0000)
      else $error("16-bit count did not wrap");
   wide_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_acc.wr_low && i_cfg.wide) |=> high_q == $past(hreg_q) && low_q == $past(i_acc.wdata))
      else $error("16-bit load not coherent");
   read_latch_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_acc.rd_low && i_cfg.wide && !i_acc.wr_high) |=> hreg_q == $past(high_q))
      else $error("high byte not latched on read");
   sync_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (step && !i_cfg.async_sel) |=> !step [*3])
      else $error("sync steps too close");
   sleep_halt_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (st_q == TMES_SLEEP) |-> !step)
      else $error("counted while asleep in sync mode");
   flag_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(out_q) |-> flag_q)
      else $error("toggle without flag");

   pbuf_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (step && !i_cfg.wide && !i_acc.wr_low && low_q == pbuf_q) |=> pbuf_q == $past(hreg_q))
      else $error("period buffer not reloaded on match");

   byte_incr_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (step && !i_cfg.wide && !i_acc.wr_low && low_q != pbuf_q) |=> low_q == $past(low_q) + 8'h01)
      else $error("8-bit count did not step");

   wide_incr_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (step && i_cfg.wide && !i_acc.wr_low)
      |=> {high_q, low_q} == $past({high_q, low_q}) + 16'h0001)
      else $error("16-bit count did not step");

   wide_no_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_cfg.wide |=> pbuf_q == $past(pbuf_q))
      else $error("period buffer moved in 16-bit mode");

   byte_high_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_cfg.wide |=> high_q == $past(high_q))
      else $error("high count moved in 8-bit mode");

   high_buf_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_acc.wr_high && !(i_acc.rd_low && i_cfg.wide)) |=> hreg_q == $past(i_acc.wdata))
      else $error("high write not buffered");

   byte_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_acc.wr_low && !i_cfg.wide) |=> low_q == $past(i_acc.wdata) && high_q == $past(high_q))
      else $error("8-bit low write wrong");

   idle_no_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (st_q == TMES_IDLE) |-> !step)
      else $error("stepped while disabled");

   off_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_cfg.on |=> st_q == TMES_IDLE)
      else $error("not idle after disable");

   on_run_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (st_q == TMES_IDLE && i_cfg.on) |=> st_q == TMES_RUN)
      else $error("did not start after enable");

   sleep_enter_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (st_q == TMES_RUN && i_cfg.on && i_sleep && !i_cfg.async_sel) |=> st_q == TMES_SLEEP)
      else $error("sync mode did not park in sleep");

   async_awake_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_cfg.async_sel && i_cfg.on && st_q != TMES_IDLE) |=> st_q == TMES_RUN)
      else $error("async mode not running");

   async_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (st_q == TMES_RUN && i_cfg.async_sel && !clr) |-> step == pre_tick)
      else $error("async step not direct");

   sync_slot_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (step && !i_cfg.async_sel) |-> div_q == SYNC_DIV_LAST)
      else $error("sync step outside slot");

   clear_post_a: assert property (@(posedge i_clk) disable iff (i_rst)
      clr |=> post_q == 4'h0)
      else $error("postscaler not cleared");

   post_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (event_hit && !clr && post_q != i_cfg.out_div) |=> post_q == $past(post_q) + 4'h1)
      else $error("postscaler did not count");

   toggle_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
      toggle |=> out_q != $past(out_q))
      else $error("output did not toggle");

   out_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !toggle |=> $stable(out_q))
      else $error("output moved without toggle");

   flag_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (toggle && i_flag_clear) |=> flag_q)
      else $error("clear beat flag set");

   flag_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_flag_clear && !toggle) |=> !flag_q)
      else $error("flag not cleared");

   flag_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (!toggle && !i_flag_clear) |=> $stable(flag_q))
      else $error("flag moved without cause");

   byte_hit_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (step && !i_cfg.wide && !i_acc.wr_low) |-> event_hit == (low_q == pbuf_q))
      else $error("8-bit match wrong");

   wide_hit_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (step && i_cfg.wide && !i_acc.wr_low) |-> event_hit == ({high_q, low_q} == 16'hFFFF))
      else $error("16-bit rollover event wrong");

   byte_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_acc.rd_low && !i_cfg.wide && !i_acc.wr_high) |=> $stable(hreg_q))
      else $error("8-bit read latched high");
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import tmes_pkg::*;
   // access masks: wr_low, wr_high, rd_low, wr_ctl0, wr_ctl1
   localparam logic [4:0] WL = 5'h10;
   localparam logic [4:0] WH = 5'h08;
   localparam logic [4:0] RL = 5'h04;
   localparam logic [4:0] WC = 5'h03;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   tmes_cfg_t cfg = '0;
   tmes_acc_t acc = '0;
   logic irq_en = 1'b0;
   logic fclr = 1'b0;
   logic slp = 1'b0;
   logic [7:0] src = 8'h00;
   logic [7:0] cnt;
   logic [7:0] per;
   logic tog;
   logic flg;
   logic irq;
   int bad_count = 0;
   int checks_done = 0;
   always #12.5 i_clk = ~i_clk;
   tmes_timer dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cfg(cfg), .i_acc(acc),
      .i_irq_enable(irq_en), .i_flag_clear(fclr), .i_sleep(slp), .i_clk_src(src),
      .o_count_low(cnt), .o_period_high(per), .o_timer_output_toggle(tog),
      .o_timer_irq_flag(flg), .o_irq(irq));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      #1;
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic wr(input logic [4:0] m, input logic [7:0] d);
      cyc(1);
      acc <= {m, d};
      cyc(1);
      acc <= '0;
      cyc(1);
   endtask
   // slow source edges leave room for the four-clock sync slot plus one held tick
   task automatic edg(input int s, input int n);
      repeat (n) begin
         cyc(1);
         src[s] <= 1'b1;
         cyc(4);
         src[s] <= 1'b0;
         cyc(4);
      end
   endtask
   // cfg bits: on, wide, out_div[3:0], clk_src[2:0], async_sel, in_div[3:0]
   task automatic setc(input logic [13:0] v);
      cyc(1);
      cfg <= v;
      wr(WC, 8'h00);
   endtask
   task automatic clr_flag;
      cyc(1);
      fclr <= 1'b1;
      irq_en <= 1'b1;
      cyc(1);
      fclr <= 1'b0;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic t_reset;
      chk(cnt, 8'h00);
      chk({5'h00, tog, flg, irq}, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_byte;
      setc(14'h2010);
      wr(WH, 8'h03);
      chk(per, 8'h03);
      edg(0, 1);
      chk(cnt, 8'h00);
      chk({5'h00, tog, flg, irq}, 8'h06);
      wr(WH, 8'h01);
      edg(0, 3);
      chk(cnt, 8'h03);
      edg(0, 3);
      chk(cnt, 8'h00);
      chk({5'h00, tog, flg, irq}, 8'h06);
      setc(14'h2110);
      wr(WH, 8'h00);
      clr_flag();
      edg(0, 2);
      chk({5'h00, tog, flg, irq}, 8'h04);
      edg(0, 1);
      chk({5'h00, tog, flg, irq}, 8'h03);
      $display("t_byte done");
   endtask
   task automatic t_wide;
      setc(14'h3010);
      clr_flag();
      wr(WH, 8'hFF);
      chk(per, 8'hFF);
      wr(WL, 8'hFE);
      chk(cnt, 8'hFE);
      edg(0, 3);
      chk(cnt, 8'h01);
      chk(per, 8'hFF);
      wr(RL, 8'h00);
      chk(per, 8'h00);
      chk({5'h00, tog, flg, irq}, 8'h07);
      $display("t_wide done");
   endtask
   task automatic t_pre;
      setc(14'h3012);
      wr(WH, 8'h00);
      wr(WL, 8'h00);
      edg(0, 3);
      chk(cnt, 8'h00);
      edg(0, 1);
      chk(cnt, 8'h01);
      edg(0, 2);
      wr(WL, 8'h05);
      edg(0, 3);
      chk(cnt, 8'h05);
      edg(0, 1);
      chk(cnt, 8'h06);
      $display("t_pre done");
   endtask
   task automatic t_gate;
      setc(14'h3050);
      edg(0, 1);
      chk(cnt, 8'h06);
      edg(2, 1);
      chk(cnt, 8'h07);
      cyc(1);
      slp <= 1'b1;
      edg(2, 1);
      chk(cnt, 8'h08);
      setc(14'h3040);
      edg(2, 1);
      chk(cnt, 8'h08);
      cyc(1);
      slp <= 1'b0;
      edg(2, 1);
      chk(cnt, 8'h09);
      setc(14'h1040);
      edg(2, 1);
      chk(cnt, 8'h09);
      chk({5'h00, tog, flg, irq}, 8'h07);
      $display("t_gate done");
   endtask
   initial begin
      cyc(5000);
      bad_count++;
      $display("[ERR] %0t run hung", $time);
      print_verdict();
   end
   initial begin
      cyc(3);
      i_rst <= 1'b0;
      cyc(1);
      t_reset();
      t_byte();
      t_wide();
      t_pre();
      t_gate();
      print_verdict();
   end
endmodule
